// ---- logic/sfpm_core.sv ----
// Two-wire target serving the identification and diagnostic memories
// Summary of operation
// R1: Reads at address 0xA0 return the 256-byte identification memory.
// R2: Reads at address 0xA2 return a separate 256-byte diagnostic memory.
// R3: All data moves by the usual serial EEPROM read and write protocol, host as controller.
// R4: The identification memory holds fixed product data, not live conditions.
// R5: The diagnostic memory carries live temperature, supply, bias, tx and rx power readings.
// R6: Readings arrive already calibrated, so the host needs no constants.
// R7: The host can switch off the transmitter and see laser fault and signal loss.
// R8: Transmitter-off and signal-loss bits track their hardware signals.
// R9: Byte 110 bit 6 is a writable soft transmitter-off, ORed with the hardware disable.
// R10: Byte 110 bit 7 shows the present transmitter-off state; here it shows only the hardware disable.
// R11: Byte 110 bit 2 shows the latched laser fault, cleared by toggling disable or power.
// R12: Byte 110 bit 1 shows receive signal loss, high meaning unusable input.
// R13: Writes to fixed or read-only bytes are acknowledged but change nothing.
`timescale 1ns/10ps
`default_nettype none
module sfpm_core (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic tx_disable_i,
  input wire logic laser_fault_i,
  input wire logic receive_signal_lost_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] vcc_i,
  input wire logic [15:0] bias_i,
  input wire logic [15:0] tx_power_i,
  input wire logic [15:0] rx_power_i,
  input wire logic [7:0] id_wdata_i,
  input wire logic [7:0] id_waddr_i,
  input wire logic id_we_i,
  output logic tx_off_o,
  output logic fault_o
);
  // ----------------------------------------
  // Pin and status synchronisers
  // ----------------------------------------
  logic [4:0] raw_in;
  logic [4:0] sync_in;
  logic scl_s;
  logic sda_s;
  logic dis_s;
  logic flt_s;
  logic flt_n_s;
  logic los_s;
  // Fault enters inverted: the synchroniser resets high, which must read as no fault
  assign raw_in = {receive_signal_lost_i, ~laser_fault_i, tx_disable_i, sda_i, scl_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      sfpm_sync u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i(raw_in[gi]),
        .q_o(sync_in[gi])
      );
    end
  endgenerate
  assign {los_s, flt_n_s, dis_s, sda_s, scl_s} = sync_in;
  assign flt_s = ~flt_n_s;

  // ----------------------------------------
  // Identification memory, loaded by the factory port only
  // ----------------------------------------
  logic [7:0] id_mem [0:255];
  always_ff @(posedge clock_i) begin
    if (id_we_i) begin
      id_mem[id_waddr_i] <= id_wdata_i; // R4
    end
  end

  // ----------------------------------------
  // Transmitter control and fault latch
  // ----------------------------------------
  logic soft_off_q, soft_off_d;
  logic fault_q, fault_d;
  logic dis_prev_q;
  logic tx_off_d;
  logic [7:0] status_byte;
  always_comb begin
    fault_d = fault_q;
    if (dis_s != dis_prev_q) begin
      fault_d = 1'b0; // R11
    end
    if (flt_s) begin
      fault_d = 1'b1; // R11
    end
    tx_off_d = dis_s | soft_off_q | fault_d; // R7 R9
    status_byte = 8'h00;
    status_byte[sfpm_pkg::TXOFF_STATE_BIT] = dis_s; // R8 R10
    status_byte[sfpm_pkg::SOFT_TXOFF_BIT] = soft_off_q; // R7
    status_byte[sfpm_pkg::FAULT_BIT] = fault_q; // R7 R11
    status_byte[sfpm_pkg::LOS_BIT] = los_s; // R8 R12
  end

  // Diagnostic read mux: readings are sampled live, already calibrated upstream
  function automatic logic [7:0] diag_byte(input logic [7:0] a, input logic [7:0] st,
      input logic [79:0] mon);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      sfpm_pkg::TEMP_MSB_OFS: r = mon[79:72];
      sfpm_pkg::TEMP_MSB_OFS + 8'h01: r = mon[71:64];
      sfpm_pkg::VCC_MSB_OFS: r = mon[63:56];
      sfpm_pkg::VCC_MSB_OFS + 8'h01: r = mon[55:48];
      sfpm_pkg::BIAS_MSB_OFS: r = mon[47:40];
      sfpm_pkg::BIAS_MSB_OFS + 8'h01: r = mon[39:32];
      sfpm_pkg::TXPWR_MSB_OFS: r = mon[31:24];
      sfpm_pkg::TXPWR_MSB_OFS + 8'h01: r = mon[23:16];
      sfpm_pkg::RXPWR_MSB_OFS: r = mon[15:8];
      sfpm_pkg::RXPWR_MSB_OFS + 8'h01: r = mon[7:0];
      sfpm_pkg::STATUS_OFS: r = st;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : diag_byte

  // ----------------------------------------
  // Two-wire target engine
  // ----------------------------------------
  sfpm_pkg::sfpm_state_type st_q, st_d;
  logic scl_p_q, sda_p_q;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic diag_q, diag_d;
  logic rd_q, rd_d;
  logic first_q, first_d;
  logic drive_q, drive_d;
  logic sda_out_q, sda_out_d;
  logic rise, fall, start, stop;
  logic [7:0] rbyte;
  always_comb begin
    rise = scl_s & ~scl_p_q;
    fall = ~scl_s & scl_p_q;
    start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
    rbyte = diag_q ? diag_byte(ptr_q, status_byte,
        {temp_i, vcc_i, bias_i, tx_power_i, rx_power_i}) : id_mem[ptr_q]; // R1 R2 R5 R6
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    diag_d = diag_q;
    rd_d = rd_q;
    first_d = first_q;
    drive_d = drive_q;
    sda_out_d = sda_out_q;
    soft_off_d = soft_off_q;
    if (start) begin // R3
      st_d = sfpm_pkg::ST_ADDR;
      cnt_d = 4'h0;
      drive_d = 1'b0;
    end else if (stop) begin
      st_d = sfpm_pkg::ST_IDLE;
      drive_d = 1'b0;
    end else begin
      case (st_q)
        sfpm_pkg::ST_IDLE: begin
          drive_d = 1'b0;
        end
        sfpm_pkg::ST_ADDR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (sh_q[7:1] == sfpm_pkg::ID_ADDR || sh_q[7:1] == sfpm_pkg::DIAG_ADDR) begin
              diag_d = (sh_q[7:1] == sfpm_pkg::DIAG_ADDR);
              rd_d = sh_q[0];
              first_d = 1'b1;
              drive_d = 1'b1;
              sda_out_d = 1'b0;
              st_d = sfpm_pkg::ST_ACK;
            end else begin
              st_d = sfpm_pkg::ST_IDLE;
            end
          end
        end
        sfpm_pkg::ST_ACK: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rd_q) begin
              drive_d = ~rbyte[7];
              sda_out_d = 1'b0;
              sh_d = {rbyte[6:0], 1'b0};
              ptr_d = ptr_q + 8'h01;
              st_d = sfpm_pkg::ST_RD;
            end else begin
              drive_d = 1'b0;
              st_d = sfpm_pkg::ST_WR;
            end
          end
        end
        sfpm_pkg::ST_WR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (first_q) begin
              ptr_d = sh_q;
              first_d = 1'b0;
            end else begin
              if (diag_q && ptr_q == sfpm_pkg::STATUS_OFS) begin
                soft_off_d = sh_q[sfpm_pkg::SOFT_TXOFF_BIT]; // R9
              end
              ptr_d = ptr_q + 8'h01; // R13
            end
            drive_d = 1'b1;
            sda_out_d = 1'b0;
            st_d = sfpm_pkg::ST_ACK;
          end
        end
        sfpm_pkg::ST_RD: begin
          if (fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              drive_d = 1'b0;
              st_d = sfpm_pkg::ST_RACK;
            end else begin
              drive_d = ~sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        sfpm_pkg::ST_RACK: begin
          if (rise) begin
            st_d = sda_s ? sfpm_pkg::ST_IDLE : sfpm_pkg::ST_ACK;
          end
        end
        default: st_d = sfpm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= sfpm_pkg::ST_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      diag_q <= 1'b0;
      rd_q <= 1'b0;
      first_q <= 1'b0;
      drive_q <= 1'b0;
      sda_out_q <= 1'b0;
      soft_off_q <= sfpm_pkg::SOFT_TXOFF_RST;
      fault_q <= 1'b0;
      dis_prev_q <= 1'b1;
      tx_off_o <= 1'b1;
      fault_o <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      diag_q <= diag_d;
      rd_q <= rd_d;
      first_q <= first_d;
      drive_q <= drive_d;
      sda_out_q <= sda_out_d;
      soft_off_q <= soft_off_d;
      fault_q <= fault_d;
      dis_prev_q <= dis_s;
      tx_off_o <= tx_off_d;
      fault_o <= fault_d;
      sda_o <= sda_out_d;
      sda_oe_o <= drive_d;
    end
  end
endmodule : sfpm_core
`default_nettype wire

// ---- logic/sfpm_pkg.sv ----
// Package for the module identification and diagnostic memory target
package sfpm_pkg;
  // ----------------------------------------
  // Target addresses (7-bit, as carried on the wire before the R/W bit)
  // ----------------------------------------
  localparam logic [6:0] ID_ADDR = 7'h50;
  localparam logic [6:0] DIAG_ADDR = 7'h51;
  // ----------------------------------------
  // Diagnostic map
  // ----------------------------------------
  localparam logic [7:0] TEMP_MSB_OFS = 8'h60;
  localparam logic [7:0] VCC_MSB_OFS = 8'h62;
  localparam logic [7:0] BIAS_MSB_OFS = 8'h64;
  localparam logic [7:0] TXPWR_MSB_OFS = 8'h66;
  localparam logic [7:0] RXPWR_MSB_OFS = 8'h68;
  localparam logic [7:0] STATUS_OFS = 8'h6e;
  localparam int TXOFF_STATE_BIT = 7;
  localparam int SOFT_TXOFF_BIT = 6;
  localparam int FAULT_BIT = 2;
  localparam int LOS_BIT = 1;
  localparam logic SOFT_TXOFF_RST = 1'b0;
  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_WR = 6'h08,
    ST_RD = 6'h10,
    ST_RACK = 6'h20
  } sfpm_state_type;
endpackage : sfpm_pkg

// ---- logic/sfpm_sync.sv ----
// Two-flop synchroniser for one bit
`timescale 1ns/10ps
`default_nettype none
module sfpm_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic meta_d;
  logic sync_d;
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end
  // Reset to one: the idle level of the pulled-up bus lines
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q_o <= sync_d;
    end
  end
endmodule : sfpm_sync
`default_nettype wire

// ---- testbench/sfpm_core_checker.sv ----
// Assertions on the two-wire target's pins and transmitter control
`timescale 1ns/10ps
`default_nettype none
module sfpm_core_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic tx_disable_i,
  input wire logic laser_fault_i,
  input wire logic tx_off_o,
  input wire logic fault_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Two-wire pin
  // ----------------------------------------
  chk_open_drain: assert property (sda_o == 1'b0) else $error("data driven high");
  chk_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*4]) else $error("pull too short");
  // Moving data while the clock is high would read as a start or stop
  chk_pull_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved");
  // ----------------------------------------
  // Transmitter control
  // ----------------------------------------
  chk_hw_off: assert property (tx_disable_i [*5] |-> tx_off_o) else $error("hw off lost");
  chk_fault_off: assert property (fault_o |-> tx_off_o) else $error("fault not off");
  chk_fault_set: assert property (laser_fault_i [*5] |-> fault_o) else $error("fault missed");
  chk_fault_keep: assert property ($stable(tx_disable_i) [*6] ##0 fault_o |=> fault_o)
    else $error("fault dropped");
  chk_reset_state: assert property (disable iff (1'b0)
    !rst_n_i ##1 !rst_n_i |-> tx_off_o && !fault_o && !sda_oe_o) else $error("bad reset state");
endmodule : sfpm_core_checker
bind sfpm_core sfpm_core_checker chk_inst (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .tx_disable_i(tx_disable_i),
  .laser_fault_i(laser_fault_i),
  .tx_off_o(tx_off_o),
  .fault_o(fault_o)
);
`default_nettype wire

// ---- testbench/sfpm_host.sv ----
// Behavioural host controller for the two-wire link
`timescale 1ns/10ps
`default_nettype none
module sfpm_host (
  input wire logic clock_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  // Each task waits first so data never moves on the edge that drops the clock
  task automatic start();
    tick(2);
    sda_pull_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    sda_pull_o <= 1'b1;
    tick(3);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    sda_pull_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    sda_pull_o <= 1'b0;
    tick(4);
  endtask : stop
  // Nine bits MSB first: 6 clocks low, 2 high, giving an 800 ns link period
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_pull_o <= ~tx[i];
      tick(4);
      scl_o <= 1'b1;
      tick(1);
      rx[i] = sda_i;
      tick(1);
      scl_o <= 1'b0;
    end
  endtask : xfer
endmodule : sfpm_host
`default_nettype wire

// ---- testbench/test_sfpm_core.sv ----
// Self-checking bench for the identification and diagnostic target
`timescale 1ns/10ps
`default_nettype none
module test_sfpm_core;
  logic clock_i, rst_n_i, tx_dis, fault_in, lost, id_we, scl, pull, sda_oe, sda_o, tx_off, fault;
  logic [15:0] mon [5];
  logic [7:0] id_waddr, id_wdata;
  logic [8:0] r;
  int num_errors, checks, cycles;
  // Pull-up on the data line: high unless someone pulls
  wire logic sda = ~pull & ~(sda_oe & ~sda_o);
  sfpm_core dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .tx_disable_i(tx_dis), .laser_fault_i(fault_in),
    .receive_signal_lost_i(lost), .temp_i(mon[0]), .vcc_i(mon[1]), .bias_i(mon[2]),
    .tx_power_i(mon[3]), .rx_power_i(mon[4]), .id_wdata_i(id_wdata), .id_waddr_i(id_waddr),
    .id_we_i(id_we), .tx_off_o(tx_off), .fault_o(fault));
  sfpm_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic close_out();
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic addr(input logic [7:0] dev, input logic [7:0] ofs);
    host.start();
    host.xfer({dev, 1'b1}, r);
    chk(16'(r[0]), 16'h0000);
    host.xfer({ofs, 1'b1}, r);
    chk(16'(r[0]), 16'h0000);
  endtask : addr
  // Two-byte read with repeated start: first byte acked, second not
  task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] exp);
    logic [8:0] a;
    addr(dev, ofs);
    host.start();
    host.xfer({dev | 8'h01, 1'b1}, r);
    chk(16'(r[0]), 16'h0000);
    host.xfer({8'hff, 1'b0}, a);
    host.xfer({8'hff, 1'b1}, r);
    host.stop();
    chk({a[8:1], r[8:1]}, exp);
  endtask : rd
  task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] data);
    addr(dev, ofs);
    host.xfer({data, 1'b1}, r);
    chk(16'(r[0]), 16'h0000);
    host.stop();
  endtask : wr
  initial begin
    rst_n_i = 1'b0;
    tx_dis = 1'b1;
    fault_in = 1'b0;
    lost = 1'b0;
    id_we = 1'b0;
    id_waddr = 8'h00;
    id_wdata = 8'h00;
    for (int i = 0; i < 5; i++) mon[i] = 16'h1a2b + 16'(i) * 16'h1111;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tx_dis <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_i);
      id_we <= 1'b1;
      id_waddr <= 8'hfe + 8'(i);
      id_wdata <= i ? 8'h5a : 8'ha5;
    end
    @(posedge clock_i);
    id_we <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk(16'(tx_off), 16'h0000);
    rd(8'ha0, 8'hfe, 16'ha55a);
    wr(8'ha0, 8'hfe, 8'h00);
    rd(8'ha0, 8'hfe, 16'ha55a);
    wr(8'ha2, 8'h60, 8'hff);
    for (int i = 0; i < 5; i++) rd(8'ha2, 8'h60 + 8'(2 * i), mon[i]);
    mon[0] <= 16'h0e0f;
    rd(8'ha2, 8'h60, 16'h0e0f);
    host.start();
    host.xfer({8'ha4, 1'b1}, r);
    host.stop();
    chk(16'(r[0]), 16'h0001);
    lost <= 1'b1;
    wr(8'ha2, 8'h6e, 8'h40);
    chk(16'(tx_off), 16'h0001);
    rd(8'ha2, 8'h6e, 16'h4200);
    wr(8'ha2, 8'h6e, 8'h00);
    fault_in <= 1'b1;
    repeat (8) @(posedge clock_i);
    fault_in <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0003);
    rd(8'ha2, 8'h6e, 16'h0600);
    tx_dis <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(8'ha2, 8'h6e, 16'h8200);
    tx_dis <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0000);
    wr(8'ha2, 8'h6e, 8'h40);
    // One-cycle fault in the same cycle as a disable toggle: the set must win
    fault_in <= 1'b1;
    tx_dis <= 1'b1;
    @(posedge clock_i);
    fault_in <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0003);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0001);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0001);
    tx_dis <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(16'({fault, tx_off}), 16'h0000);
    rd(8'ha2, 8'h6e, 16'h0200);
    close_out();
  end
endmodule : test_sfpm_core
`default_nettype wire
